// ### hw/oat_pkg.sv
// package for the converter offset and sample-delay trim bank
// assumes a 32-bit apb master and fuse values valid from reset onward
package oat_pkg;

   ////////////////////////////////////////////////////////////////////////
   // bus widths
   localparam int OAT_ADDR_W = 12;
   localparam int OAT_DATA_W = 32;

   // register indices; the byte address is four times the index
   localparam logic [9:0] OAT_IDX_B_DELAY = 10'h31b;
   localparam logic [9:0] OAT_IDX_A_DUAL_FIRST = 10'h344;
   localparam logic [9:0] OAT_IDX_A_DUAL_SECOND = 10'h346;
   localparam logic [9:0] OAT_IDX_A_SINGLE_FIRST = 10'h348;
   localparam logic [9:0] OAT_IDX_A_SINGLE_SECOND = 10'h34a;
   localparam logic [9:0] OAT_IDX_B_FIRST = 10'h34c;
   localparam logic [9:0] OAT_IDX_CTRL = 10'h360;
   localparam logic [9:0] OAT_IDX_STATUS = 10'h361;

   ////////////////////////////////////////////////////////////////////////
   // field layout
   localparam int OAT_OFS_LSB = 0;
   localparam int OAT_OFS_W = 12;
   localparam int OAT_REG_W = 16;
   localparam int OAT_DLY_W = 8;
   localparam int OAT_CTRL_W = 4;
   localparam int OAT_CTRL_SINGLE = 0;
   localparam int OAT_CTRL_FG_EN = 1;
   localparam int OAT_CTRL_A_SECOND = 2;
   localparam int OAT_CTRL_B_SECOND = 3;
   localparam int OAT_STAT_A_VALID = 12;
   localparam int OAT_STAT_B_OFS_VALID = 13;
   localparam int OAT_STAT_B_DLY_VALID = 14;
   localparam int OAT_STAT_RUN = 15;

   // reset values
   localparam logic [15:0] OAT_OFS_RST = 16'h0000;
   localparam logic [7:0] OAT_DLY_RST = 8'h01;
   localparam logic [3:0] OAT_CTRL_RST = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [0:0] {
      OAT_ST_FUSE = 1'b0,
      OAT_ST_RUN = 1'b1
   } oat_fsm_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } oat_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } oat_apb_rsp_t;

   typedef struct packed {
      logic [11:0] a_dual_first;
      logic [11:0] a_dual_second;
      logic [11:0] a_single_first;
      logic [11:0] a_single_second;
      logic [11:0] b_first;
      logic [7:0] b_delay;
   } oat_fuse_t;

   typedef struct packed {
      logic [15:0] a_dual_first;
      logic [15:0] a_dual_second;
      logic [15:0] a_single_first;
      logic [15:0] a_single_second;
      logic [15:0] b_first;
      logic [7:0] b_delay;
   } oat_bank_t;

   // one core's view of the operating mode
   typedef struct packed {
      logic single_mode;
      logic fg_en;
      logic sel_second;
   } oat_mode_t;

   typedef struct packed {
      logic [11:0] offset;
      logic offset_valid;
      logic [7:0] delay;
      logic delay_valid;
   } oat_trim_t;

   // offset field of a 16-bit trim register
   function automatic logic [11:0] oat_ofs_of(input logic [15:0] r);
      return r[OAT_OFS_LSB +: OAT_OFS_W];
   endfunction

endpackage

// ### hw/oat_trim_sel.sv
// picks the trim values that apply to one converter core
// assumes a stable mode view and a registered bank; purely combinational
`timescale 1ns/10ps

module oat_trim_sel (
   input wire logic core_is_b, // high selects the b core table
   input wire oat_pkg::oat_mode_t mode, // mode view of this core
   input wire oat_pkg::oat_bank_t bank, // held trim registers
   output oat_pkg::oat_trim_t trim // values the core applies
);
   import oat_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // nothing applies unless foreground calibration is on
   always_comb begin
      trim = '0;
      if (mode.fg_en) begin
         if (!core_is_b) begin
            trim.offset_valid = 1'b1;
            case ({mode.single_mode, mode.sel_second})
               2'b00: trim.offset = oat_ofs_of(bank.a_dual_first);
               2'b01: trim.offset = oat_ofs_of(bank.a_dual_second);
               2'b10: trim.offset = oat_ofs_of(bank.a_single_first);
               2'b11: trim.offset = oat_ofs_of(bank.a_single_second);
               default: trim.offset_valid = 1'b0;
            endcase
         end else if (!mode.sel_second) begin
            // same value in both channel modes
            trim.offset = oat_ofs_of(bank.b_first);
            trim.offset_valid = 1'b1;
         end else if (mode.single_mode) begin
            // b second-input offset lives outside this bank
            trim.delay = bank.b_delay;
            trim.delay_valid = 1'b1;
         end
      end
   end

endmodule

// ### hw/oat_regs.sv
// apb register bank holding offset and sample-delay trims for two cores
// assumes a 32-bit apb master and fuse values stable from reset onward
//
// Behaviour
// - a dual first input uses its offset
// - a dual second input uses its offset
// - a single first input uses its offset
// - a second input on ninety phase offset
// - b first input offset in both modes
// - b single second input shifts sample instant
// - b first offset loads from fuse
// - delay default from fuse, readable, writable
`timescale 1ns/10ps

module oat_regs (
   input wire logic sys_clk, // 125 mhz clock
   input wire logic rst, // synchronous reset, active high
   input wire oat_pkg::oat_apb_req_t apb_req, // apb request group
   output oat_pkg::oat_apb_rsp_t apb_rsp, // apb answer group
   input wire oat_pkg::oat_fuse_t fuse_in, // factory trim values
   output oat_pkg::oat_trim_t a_trim, // trims applied to core a
   output oat_pkg::oat_trim_t b_trim // trims applied to core b
);
   import oat_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      oat_fsm_t fsm;
      oat_bank_t bank;
      logic [3:0] ctrl;
      logic [31:0] prdata;
      logic pslverr;
      oat_trim_t a_trim;
      oat_trim_t b_trim;
   } oat_state_t;

   localparam oat_state_t OAT_STATE_RST = '{
      fsm: OAT_ST_FUSE,
      bank: '{
         a_dual_first: OAT_OFS_RST,
         a_dual_second: OAT_OFS_RST,
         a_single_first: OAT_OFS_RST,
         a_single_second: OAT_OFS_RST,
         b_first: OAT_OFS_RST,
         b_delay: OAT_DLY_RST
      },
      ctrl: OAT_CTRL_RST,
      prdata: '0,
      pslverr: 1'b0,
      a_trim: '0,
      b_trim: '0
   };

   oat_state_t s_r;
   oat_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge of a 16-bit trim register
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wdata,
      input logic [3:0] strb
   );
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         r[15:8] = wdata[15:8];
      end
      return r;
   endfunction

   // byte-lane merge of an 8-bit register
   function automatic logic [7:0] merge8(
      input logic [7:0] old,
      input logic [31:0] wdata,
      input logic [3:0] strb
   );
      return strb[0] ? wdata[7:0] : old;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   logic [9:0] idx;
   logic setup;
   logic pready;
   logic wr_take;
   logic hit;
   logic [31:0] rdata;
   logic [15:0] status;
   logic [7:0] ctrl_wr;

   assign idx = apb_req.paddr[11:2];
   assign setup = apb_req.psel && !apb_req.penable;

   // bus waits while fuse values are still being copied in
   assign pready = apb_req.psel && apb_req.penable && (s_r.fsm == OAT_ST_RUN);
   assign wr_take = pready && apb_req.pwrite;

   // control merged at lane width first; a call result cannot be sliced
   assign ctrl_wr = merge8({4'h0, s_r.ctrl}, apb_req.pwdata, apb_req.pstrb);

   // live state shown to software
   always_comb begin
      status = '0;
      status[OAT_OFS_LSB +: OAT_OFS_W] = s_r.a_trim.offset;
      status[OAT_STAT_A_VALID] = s_r.a_trim.offset_valid;
      status[OAT_STAT_B_OFS_VALID] = s_r.b_trim.offset_valid;
      status[OAT_STAT_B_DLY_VALID] = s_r.b_trim.delay_valid;
      status[OAT_STAT_RUN] = (s_r.fsm == OAT_ST_RUN);
   end

   // read mux; trim reserved bits 15:12 come back as written, bits above each register read zero
   always_comb begin
      hit = 1'b1;
      rdata = '0;
      case (idx)
         OAT_IDX_B_DELAY: rdata = {24'h000000, s_r.bank.b_delay};
         OAT_IDX_A_DUAL_FIRST: rdata = {16'h0000, s_r.bank.a_dual_first};
         OAT_IDX_A_DUAL_SECOND: rdata = {16'h0000, s_r.bank.a_dual_second};
         OAT_IDX_A_SINGLE_FIRST: rdata = {16'h0000, s_r.bank.a_single_first};
         OAT_IDX_A_SINGLE_SECOND: rdata = {16'h0000, s_r.bank.a_single_second};
         OAT_IDX_B_FIRST: rdata = {16'h0000, s_r.bank.b_first};
         OAT_IDX_CTRL: rdata = {28'h0000000, s_r.ctrl};
         OAT_IDX_STATUS: rdata = {16'h0000, status};
         default: hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // mode views and trim selection

   oat_mode_t a_mode;
   oat_mode_t b_mode;
   oat_trim_t a_sel;
   oat_trim_t b_sel;

   // both cores share channel mode and calibration enable
   assign a_mode = '{
      single_mode: s_r.ctrl[OAT_CTRL_SINGLE],
      fg_en: s_r.ctrl[OAT_CTRL_FG_EN],
      sel_second: s_r.ctrl[OAT_CTRL_A_SECOND]
   };
   assign b_mode = '{
      single_mode: s_r.ctrl[OAT_CTRL_SINGLE],
      fg_en: s_r.ctrl[OAT_CTRL_FG_EN],
      sel_second: s_r.ctrl[OAT_CTRL_B_SECOND]
   };

   // core a table
   oat_trim_sel u_sel_a (
      .core_is_b(1'b0),
      .mode(a_mode),
      .bank(s_r.bank),
      .trim(a_sel)
   );

   // core b table
   oat_trim_sel u_sel_b (
      .core_is_b(1'b1),
      .mode(b_mode),
      .bank(s_r.bank),
      .trim(b_sel)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_nxt = s_r;
      case (s_r.fsm)
         OAT_ST_FUSE: begin
            // factory values replace the reset constants, reserved bits zero
            s_nxt.bank.a_dual_first = {4'h0, fuse_in.a_dual_first};
            s_nxt.bank.a_dual_second = {4'h0, fuse_in.a_dual_second};
            s_nxt.bank.a_single_first = {4'h0, fuse_in.a_single_first};
            s_nxt.bank.a_single_second = {4'h0, fuse_in.a_single_second};
            s_nxt.bank.b_first = {4'h0, fuse_in.b_first};
            s_nxt.bank.b_delay = fuse_in.b_delay;
            s_nxt.fsm = OAT_ST_RUN;
         end
         OAT_ST_RUN: begin
            // writes land only at the access edge; status is read-only
            if (wr_take) begin
               case (idx)
                  OAT_IDX_B_DELAY: begin
                     s_nxt.bank.b_delay = merge8(s_r.bank.b_delay,
                        apb_req.pwdata, apb_req.pstrb);
                  end
                  OAT_IDX_A_DUAL_FIRST: begin
                     s_nxt.bank.a_dual_first = merge16(s_r.bank.a_dual_first,
                        apb_req.pwdata, apb_req.pstrb);
                  end
                  OAT_IDX_A_DUAL_SECOND: begin
                     s_nxt.bank.a_dual_second = merge16(s_r.bank.a_dual_second,
                        apb_req.pwdata, apb_req.pstrb);
                  end
                  OAT_IDX_A_SINGLE_FIRST: begin
                     s_nxt.bank.a_single_first = merge16(s_r.bank.a_single_first,
                        apb_req.pwdata, apb_req.pstrb);
                  end
                  OAT_IDX_A_SINGLE_SECOND: begin
                     s_nxt.bank.a_single_second = merge16(s_r.bank.a_single_second,
                        apb_req.pwdata, apb_req.pstrb);
                  end
                  OAT_IDX_B_FIRST: begin
                     s_nxt.bank.b_first = merge16(s_r.bank.b_first,
                        apb_req.pwdata, apb_req.pstrb);
                  end
                  OAT_IDX_CTRL: begin
                     s_nxt.ctrl = ctrl_wr[OAT_CTRL_W-1:0];
                  end
                  default: begin
                     s_nxt.ctrl = s_r.ctrl;
                  end
               endcase
            end
         end
         default: begin
            s_nxt.fsm = OAT_ST_FUSE;
         end
      endcase

      // read data is captured in the setup cycle so prdata is a flop
      if (setup) begin
         s_nxt.prdata = apb_req.pwrite ? 32'h00000000 : rdata;
         s_nxt.pslverr = !hit;
      end

      // trims trail the bank by one cycle, never glitch into the cores
      s_nxt.a_trim = a_sel;
      s_nxt.b_trim = b_sel;
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= OAT_STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign apb_rsp.pready = pready;
   assign apb_rsp.prdata = s_r.prdata;
   assign apb_rsp.pslverr = s_r.pslverr;
   assign a_trim = s_r.a_trim;
   assign b_trim = s_r.b_trim;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (rst);

   logic wr_delay;
   logic wr_bank;

   // a delay write with lane zero enabled
   assign wr_delay = wr_take && (idx == OAT_IDX_B_DELAY) && apb_req.pstrb[0];

   // any write that could touch the bank
   assign wr_bank = wr_take && (idx != OAT_IDX_CTRL) && (idx != OAT_IDX_STATUS);

   a_a_dual_first: assert property (
      (a_mode == 3'b010) |=>
         (a_trim.offset == $past(s_r.bank.a_dual_first[11:0])) && a_trim.offset_valid)
      else $error("core a dual first input offset wrong");

   a_a_dual_second: assert property (
      (a_mode == 3'b011) |=>
         (a_trim.offset == $past(s_r.bank.a_dual_second[11:0])) && a_trim.offset_valid)
      else $error("core a dual second input offset wrong");

   a_a_single_first: assert property (
      (a_mode == 3'b110) |=>
         (a_trim.offset == $past(s_r.bank.a_single_first[11:0])) && a_trim.offset_valid)
      else $error("core a single first input offset wrong");

   a_a_single_second: assert property (
      (a_mode == 3'b111) |=>
         (a_trim.offset == $past(s_r.bank.a_single_second[11:0])) && a_trim.offset_valid)
      else $error("core a single second input offset wrong");

   a_b_first_ofs: assert property (
      (b_mode.fg_en && !b_mode.sel_second) ##1 $stable(s_r.bank.b_first) |->
         (b_trim.offset == s_r.bank.b_first[11:0]) && b_trim.offset_valid)
      else $error("core b first input offset wrong");

   a_b_delay_use: assert property (
      (b_mode == 3'b111) |=>
         (b_trim.delay == $past(s_r.bank.b_delay)) && b_trim.delay_valid
         && !b_trim.offset_valid)
      else $error("core b sample delay not applied");

   a_fuse_load: assert property (
      (s_r.fsm == OAT_ST_FUSE) |=>
         (s_r.bank.b_first == {4'h0, $past(fuse_in.b_first)})
         && (s_r.fsm == OAT_ST_RUN))
      else $error("fuse default not loaded into core b offset");

   a_delay_write: assert property (
      wr_delay |=> (s_r.bank.b_delay == $past(apb_req.pwdata[7:0]))
         ##1 (!setup || (idx != OAT_IDX_B_DELAY) || apb_req.pwrite
         || (s_r.bank.b_delay != $past(s_r.bank.b_delay))
         || (s_nxt.prdata[7:0] == s_r.bank.b_delay)))
      else $error("sample delay write not held or read back");

   a_bank_hold: assert property (
      ((s_r.fsm == OAT_ST_RUN) && !wr_bank) |=> $stable(s_r.bank))
      else $error("trim register changed without a write");

   a_fg_off_idle: assert property (
      !s_r.ctrl[OAT_CTRL_FG_EN] |=> (a_trim == '0) && (b_trim == '0))
      else $error("trim applied with calibration off");

   a_b_dual_second: assert property (
      (b_mode == 3'b011) |=> !b_trim.offset_valid && !b_trim.delay_valid)
      else $error("core b dual second input shows a trim");

   a_read_capture: assert property (
      (setup && !apb_req.pwrite && (idx == OAT_IDX_A_SINGLE_FIRST)) |=>
         (apb_rsp.prdata == {16'h0000, $past(s_r.bank.a_single_first)})
         && !apb_rsp.pslverr)
      else $error("read data does not show the held register");

   a_unmapped_err: assert property (
      (setup && !hit) |=> apb_rsp.pslverr && (apb_rsp.prdata == 32'h00000000))
      else $error("unmapped access not refused");

   a_load_stall: assert property (
      (s_r.fsm == OAT_ST_FUSE) |-> !apb_rsp.pready)
      else $error("bus answered before fuse values were loaded");

endmodule

// ### verification/oat_regs_test.sv
// self-checking bench for the offset and sample-delay trim bank
// assumes the bank answers apb at zero wait states once the fuse load is done
`timescale 1ns/10ps

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
   $display("[FAIL] %0t value mismatch got %h exp %h", $time, (got), (exp)); end end

module oat_regs_test;
   import oat_pkg::*;

   logic sys_clk;
   logic rst;
   oat_apb_req_t req;
   oat_apb_rsp_t rsp;
   oat_fuse_t fuse;
   oat_trim_t a_trim;
   oat_trim_t b_trim;
   int err_count;
   int check_count;
   logic [31:0] rd;
   logic err;

   ////////////////////////////////////////////////////////////////////////
   // device under test
   oat_regs dut (
      .sys_clk(sys_clk),
      .rst(rst),
      .apb_req(req),
      .apb_rsp(rsp),
      .fuse_in(fuse),
      .a_trim(a_trim),
      .b_trim(b_trim)
   );

   // 125 mhz clock
   always #4 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////
   // verdict, the one place the run ends
   task automatic stop_test();
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one apb transfer; entered just after a rising edge, leaves one idle cycle
   // so the next call never reassigns psel in the same time step
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rdata, output logic perr);
      int n;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= {idx, 2'b00};
      req.pwdata <= wd;
      req.pstrb <= st;
      @(posedge sys_clk);
      req.penable <= 1'b1;
      n = 0;
      // values read here are those before this edge's updates
      do begin
         @(posedge sys_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("[FAIL] %0t no pready", $time);
         stop_test();
      end
      rdata = rsp.prdata;
      perr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd, 4'hf, rd, err);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0, 4'h0, rd, err);
      `CHK(rd, exp)
      `CHK(err, 1'b0)
   endtask

   // reset for 20 cycles; trims must sit at zero meanwhile
   task automatic do_reset();
      rst <= 1'b1;
      repeat (20) @(posedge sys_clk);
      `CHK({a_trim, b_trim}, 44'h0)
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // after reset every trim register shows its fuse value, reserved bits zero
   task automatic t_fuse_defaults();
      rd_chk(OAT_IDX_A_DUAL_FIRST, {20'h0, fuse.a_dual_first});
      rd_chk(OAT_IDX_A_DUAL_SECOND, {20'h0, fuse.a_dual_second});
      rd_chk(OAT_IDX_A_SINGLE_FIRST, {20'h0, fuse.a_single_first});
      rd_chk(OAT_IDX_A_SINGLE_SECOND, {20'h0, fuse.a_single_second});
      rd_chk(OAT_IDX_B_FIRST, {20'h0, fuse.b_first});
      rd_chk(OAT_IDX_B_DELAY, {24'h0, fuse.b_delay});
   endtask

   // reserved bits held, byte strobes honoured, upper lanes ignored
   task automatic t_hold_and_strobe();
      wr(OAT_IDX_A_SINGLE_FIRST, 32'h0000_f5a3);
      rd_chk(OAT_IDX_A_SINGLE_FIRST, 32'h0000_f5a3);
      apb(1'b1, OAT_IDX_A_SINGLE_FIRST, 32'h0000_1234, 4'b0001, rd, err);
      rd_chk(OAT_IDX_A_SINGLE_FIRST, 32'h0000_f534);
      wr(OAT_IDX_B_DELAY, 32'hffff_ffff);
      rd_chk(OAT_IDX_B_DELAY, 32'h0000_00ff);
      wr(OAT_IDX_B_DELAY, 32'h0000_0000);
      rd_chk(OAT_IDX_B_DELAY, 32'h0000_0000);
   endtask

   // unmapped index errors with no effect; status index ignores writes
   task automatic t_refused();
      wr(10'h345, 32'h0000_ffff);
      `CHK(err, 1'b1)
      apb(1'b0, 10'h345, 32'h0, 4'h0, rd, err);
      `CHK({err, rd}, 33'h1_0000_0000)
      rd_chk(OAT_IDX_A_DUAL_SECOND, {20'h0, fuse.a_dual_second});
      wr(OAT_IDX_STATUS, 32'h0000_0000);
      `CHK(err, 1'b0)
      apb(1'b0, OAT_IDX_STATUS, 32'h0, 4'h0, rd, err);
      `CHK(rd[OAT_STAT_RUN], 1'b1)
   endtask

   // set control, then judge both cores' trims two edges after it lands
   task automatic sel_case(input logic [3:0] ctrl, input logic [11:0] a_ofs, input logic a_v,
                           input logic [11:0] b_ofs, input logic b_v, input logic d_v);
      wr(OAT_IDX_CTRL, {28'h0, ctrl});
      @(posedge sys_clk);
      `CHK({a_trim.offset_valid, a_trim.offset}, {a_v, a_ofs})
      `CHK({b_trim.offset_valid, b_trim.offset}, {b_v, b_ofs})
      `CHK({b_trim.delay_valid, b_trim.delay}, {d_v, d_v ? 8'h7e : 8'h00})
   endtask

   task automatic t_select();
      wr(OAT_IDX_A_DUAL_FIRST, 32'h0000_0123);
      wr(OAT_IDX_A_DUAL_SECOND, 32'h0000_0456);
      wr(OAT_IDX_A_SINGLE_FIRST, 32'h0000_0789);
      wr(OAT_IDX_A_SINGLE_SECOND, 32'h0000_0abc);
      wr(OAT_IDX_B_FIRST, 32'h0000_0def);
      wr(OAT_IDX_B_DELAY, 32'h0000_007e);
      sel_case(4'b0010, 12'h123, 1'b1, 12'hdef, 1'b1, 1'b0);
      sel_case(4'b0110, 12'h456, 1'b1, 12'hdef, 1'b1, 1'b0);
      sel_case(4'b0011, 12'h789, 1'b1, 12'hdef, 1'b1, 1'b0);
      sel_case(4'b0111, 12'habc, 1'b1, 12'hdef, 1'b1, 1'b0);
      sel_case(4'b1011, 12'h789, 1'b1, 12'h000, 1'b0, 1'b1);
      sel_case(4'b1010, 12'h123, 1'b1, 12'h000, 1'b0, 1'b0);
      // a late offset write must reach the core without a control change
      wr(OAT_IDX_A_DUAL_FIRST, 32'h0000_0321);
      @(posedge sys_clk);
      `CHK(a_trim.offset, 12'h321)
      sel_case(4'b0000, 12'h000, 1'b0, 12'h000, 1'b0, 1'b0);
      `CHK({a_trim, b_trim}, 44'h0)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence; second reset shows writes are dropped for fuse values
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      req = '0;
      err_count = 0;
      check_count = 0;
      // distinct fuse pattern so a swapped register shows up
      fuse = {12'h1a1, 12'h2b2, 12'h3c3, 12'h4d4, 12'h5e5, 8'h5c};
      do_reset();
      t_fuse_defaults();
      t_hold_and_strobe();
      t_refused();
      t_select();
      do_reset();
      t_fuse_defaults();
      stop_test();
   end
endmodule
